// *** flash_cfg.svh ***
// Constants shared by the serial flash read port and its host controller
// Assumes inclusion by bare name from the package and the design modules
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

// Default command opcodes (chosen, overridable by parameters)
`define OP_READ 8'h03
`define OP_FAST 8'h0b
`define OP_LOCK 8'he8

// Array geometry
`define ADDR_W 20
`define SECTOR_HI 19
`define SECTOR_LO 16
`define SUB_HI 15
`define SUB_LO 12
`define FIRST_SECTOR 4'h0
`define LAST_SECTOR 4'hf

// Bit counts on the link, as last index of a phase
`define CMD_LAST 5'd7
`define ADDR_LAST 5'd23
`define DUMMY_LAST 5'd7

// Lock byte field positions
`define LK_WLOCK 0
`define LK_FREEZE 1
`define LK_SUB_WLOCK 2
`define LK_SUB_FREEZE 3

// Host serial clock: half period in pclk cycles (8 -> 640 ns period)
`define HALF_LAST 4'd7
`define TX_BITS_PLAIN 6'd32
`define TX_BITS_FAST 6'd40

// Host register offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_COUNT 8'h08
`define REG_STATUS 8'h0c
`define REG_RDATA 8'h10

// Host control fields
`define CTRL_START 8
`define SEL_READ 2'd0
`define SEL_FAST 2'd1
`define SEL_LOCK 2'd2
`endif

// *** flash_link_if.sv ***
// Four-wire serial link between host controller and flash read port
// Assumes both ends run on the same pclk; a released serial_out reads inverted
interface flash_link_if;
    logic sel_n;          // Select, active low, host driven
    logic sclk;           // Serial clock, host driven
    logic serial_in;      // Host to device data
    logic serial_out;     // Device data value
    logic serial_out_oe;  // Device drives serial_out while high
    wire serial_out_wire; // Pin level, inverted when released
    assign serial_out_wire = serial_out_oe ? serial_out : ~serial_out;
    modport device_end(input sel_n, input sclk, input serial_in,
                       output serial_out, output serial_out_oe);
    modport host_end(output sel_n, output sclk, output serial_in,
                     input serial_out_wire);
endinterface

// *** flash_link_sva.sv ***
// Checker for the serial link between host controller and flash read port
// Assumes one pclk domain and presetn asynchronous active low
module flash_link_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Device lets go of the pin soon after deselect
    property p_rel; $rose(sel_n) |-> ##[1:6] !serial_out_oe; endproperty
    a_rel: assert property (p_rel) else $error("pin kept after deselect");
    property p_idle; sel_n [*8] |-> !serial_out_oe; endproperty
    a_idle: assert property (p_idle) else $error("pin driven while idle");
    property p_early; $fell(sel_n) |-> !serial_out_oe [*8]; endproperty
    a_early: assert property (p_early) else $error("data before address");
    // Output moves only while the serial clock is low
    property p_out; $changed(serial_out) && serial_out_oe |-> !sclk; endproperty
    a_out: assert property (p_out) else $error("data moved on high clock");
    property p_on; $rose(serial_out_oe) |-> !sclk && !sel_n; endproperty
    a_on: assert property (p_on) else $error("drive began on wrong edge");
    property p_in; $changed(serial_in) |-> !sclk; endproperty
    a_in: assert property (p_in) else $error("input moved on high clock");
    property p_ck; sel_n |-> !sclk; endproperty
    a_ck: assert property (p_ck) else $error("clock high while idle");
    property p_half; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
    a_half: assert property (p_half) else $error("clock high phase wrong");
    // Main scenarios
    c_data: cover property ($rose(serial_out_oe));
    c_stop: cover property (serial_out_oe ##1 $rose(sel_n));
    c_clk: cover property (!sel_n ##1 $rose(sclk));
endmodule

// *** flash_pkg.sv ***
// Types shared by both ends of the serial flash read link
// Assumes flash_cfg.svh is on the include path
`include "flash_cfg.svh"
package flash_pkg;
    // Device command phases
    typedef enum logic [2:0] {
        dev_idle, dev_cmd, dev_addr, dev_dummy, dev_data, dev_ignore
    } dev_state_e;
    // Which read the device is serving
    typedef enum logic [1:0] {kind_read, kind_fast, kind_lock} read_kind_e;
    // Host transfer phases
    typedef enum logic [1:0] {host_idle, host_lead, host_run, host_tail} host_state_e;
    // Two lock bits: freeze above write lock
    typedef logic [1:0] lock_pair_t;
endpackage

// *** flash_read_device.sv ***
// Serial flash read port: normal read, fast read, lock register read
// Assumes a host on flash_link_if in mode 0 and a write engine on user side
// Functional notes
// R1 - Command then three address bytes, rising-edge sampled
// R2 - Data shifted out on falling edges
// R3 - Any byte may start a read
// R4 - Address increments after each byte
// R5 - Address wraps to zero past top
// R6 - Upper four address bits ignored
// R7 - Deselect ends command immediately
// R8 - Normal read refused while busy
// R9 - Fast read discards one dummy byte
// R10 - Fast read refused while busy
// R11 - Lock read returns addressed sector lock byte
// R12 - Lock read refused while busy
// R13 - Set freeze blocks lock changes until reset
// R14 - Clear freeze allows lock writes
// R15 - Write lock blocks sector modification
// R16 - Unlocked sectors writable; locks reset zero
// R17 - Lock bits seven to four read zero
// R18 - Legacy subsector lock and freeze bits
// R19 - Subsector bits only sectors 0, 15
// R20 - Busy flag gates read acceptance
// R21 - Opcodes parameters; MSB first everywhere
// R22 - Decode after eighth bit; deselect idles
//
// Chosen here: register access over APB and the placing of the registers.
`include "flash_cfg.svh"
module flash_read_device #(
    parameter logic [7:0] OP_READ = `OP_READ,
    parameter logic [7:0] OP_FAST = `OP_FAST,
    parameter logic [7:0] OP_LOCK = `OP_LOCK
) (
    input wire logic pclk,
    input wire logic presetn,
    flash_link_if.device_end link,
    input wire logic busy_flag,
    input wire logic legacy_mode,
    input wire logic mem_we,
    input wire logic [`ADDR_W-1:0] mem_waddr,
    input wire logic [7:0] mem_wdata,
    output logic mem_refused,
    input wire logic lock_we,
    input wire logic [`ADDR_W-1:0] lock_waddr,
    input wire logic [7:0] lock_wdata
);
    localparam int NSEC = 16;  // Sectors in the array
    localparam int NSUB = 16;  // Subsectors per sector

    logic sel_n_s;    // Synchronised select
    logic sclk_rise;  // Serial clock rising edge seen
    logic sclk_fall;  // Serial clock falling edge seen
    logic sin_s;      // Synchronised serial input

    link_sync #(.RESET_VAL(1'b1)) u_sel (
        .pclk(pclk), .presetn(presetn), .din(link.sel_n),
        .q(sel_n_s), .rise(), .fall()
    );
    link_sync #(.RESET_VAL(1'b0)) u_clk (
        .pclk(pclk), .presetn(presetn), .din(link.sclk),
        .q(), .rise(sclk_rise), .fall(sclk_fall)
    );
    link_sync #(.RESET_VAL(1'b0)) u_din (
        .pclk(pclk), .presetn(presetn), .din(link.serial_in),
        .q(sin_s), .rise(), .fall()
    );

    logic [7:0] mem [0:(1<<`ADDR_W)-1];  // Array contents

    // Command state
    flash_pkg::dev_state_e state, next_state;
    flash_pkg::read_kind_e kind, next_kind;
    logic [4:0] cnt, next_cnt;            // Bit index in phase
    logic [23:0] shin, next_shin;         // Incoming bits
    logic [`ADDR_W-1:0] addr, next_addr;  // Read address counter
    logic [6:0] shout, next_shout;        // Remaining output bits
    logic [2:0] obit, next_obit;          // Output bit index
    logic sout, next_sout;                // Serial output bit
    logic oe, next_oe;                    // Output enable

    // Lock state
    flash_pkg::lock_pair_t sec_lock [NSEC];         // Per sector
    flash_pkg::lock_pair_t next_sec_lock [NSEC];
    flash_pkg::lock_pair_t sub_lock [2][NSUB];      // Edge sectors only
    flash_pkg::lock_pair_t next_sub_lock [2][NSUB];

    logic [3:0] rd_sec;    // Sector under the read address
    logic [3:0] rd_sub;    // Subsector under the read address
    logic rd_edge;         // Read sector is first or last
    logic [7:0] lock_byte; // Lock value for read address
    logic [7:0] fetch;     // Byte to send next
    logic [7:0] cmd_byte;  // Command byte once eighth bit in
    logic [3:0] w_sec;     // Sector of a memory write
    logic [3:0] w_sub;     // Subsector of a memory write
    logic w_edge;          // Write sector is first or last
    logic w_blocked;       // Memory write hits a lock
    logic [3:0] l_sec;     // Sector of a lock write
    logic [3:0] l_sub;     // Subsector of a lock write
    logic l_edge;          // Lock write sector is first or last
    logic refused_q;       // Registered refusal flag

    // Lock byte and next byte for the output shifter
    always_comb begin
        rd_sec = addr[`SECTOR_HI:`SECTOR_LO];
        rd_sub = addr[`SUB_HI:`SUB_LO];
        rd_edge = (rd_sec == `FIRST_SECTOR) || (rd_sec == `LAST_SECTOR);
        lock_byte = 8'h00;  // R17
        lock_byte[`LK_FREEZE:`LK_WLOCK] = sec_lock[rd_sec];  // R11
        if (legacy_mode && rd_edge) begin
            // Subsector bits read zero for middle sectors
            lock_byte[`LK_SUB_FREEZE:`LK_SUB_WLOCK] = sub_lock[rd_sec[0]][rd_sub];  // R19
        end
        fetch = (kind == flash_pkg::kind_lock) ? lock_byte : mem[addr];
        cmd_byte = {shin[6:0], sin_s};
    end

    // Next command state from link edges
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_cnt = cnt;
        next_shin = shin;
        next_addr = addr;
        next_shout = shout;
        next_obit = obit;
        next_sout = sout;
        next_oe = oe;
        if (sel_n_s) begin
            // Deselect: abandon whatever phase is running
            next_state = flash_pkg::dev_idle;  // R7 R22
            next_cnt = 5'd0;
            next_obit = 3'd0;
            next_oe = 1'b0;
        end else begin
            unique case (state)
                flash_pkg::dev_idle: begin
                    // Selected: start collecting the command
                    next_state = flash_pkg::dev_cmd;
                    next_cnt = 5'd0;
                end
                flash_pkg::dev_cmd: begin
                    if (sclk_rise) begin
                        next_shin = {shin[22:0], sin_s};  // R21
                        next_cnt = cnt + 5'd1;
                        if (cnt == `CMD_LAST) begin  // R22
                            next_cnt = 5'd0;
                            next_state = flash_pkg::dev_addr;
                            if (busy_flag) begin
                                // Refused; running cycle untouched
                                next_state = flash_pkg::dev_ignore;  // R8 R10 R12 R20
                            end else if (cmd_byte == OP_READ) begin
                                next_kind = flash_pkg::kind_read;
                            end else if (cmd_byte == OP_FAST) begin
                                next_kind = flash_pkg::kind_fast;
                            end else if (cmd_byte == OP_LOCK) begin
                                next_kind = flash_pkg::kind_lock;
                            end else begin
                                next_state = flash_pkg::dev_ignore;
                            end
                        end
                    end
                end
                flash_pkg::dev_addr: begin
                    if (sclk_rise) begin
                        next_shin = {shin[22:0], sin_s};  // R1
                        next_cnt = cnt + 5'd1;
                        if (cnt == `ADDR_LAST) begin
                            // Any byte may start; top four bits dropped
                            next_addr = {shin[`ADDR_W-2:0], sin_s};  // R3 R6
                            next_cnt = 5'd0;
                            next_state = (kind == flash_pkg::kind_fast) ?
                                flash_pkg::dev_dummy : flash_pkg::dev_data;
                        end
                    end
                end
                flash_pkg::dev_dummy: begin
                    if (sclk_rise) begin
                        // Dummy bits counted and thrown away
                        next_cnt = cnt + 5'd1;  // R9
                        if (cnt == `DUMMY_LAST) begin
                            next_state = flash_pkg::dev_data;
                        end
                    end
                end
                flash_pkg::dev_data: begin
                    if (sclk_fall) begin
                        next_oe = 1'b1;
                        next_obit = obit + 3'd1;
                        if (obit == 3'd0) begin
                            // New byte: first bit out, advance address except for lock reads
                            next_sout = fetch[7];  // R2
                            next_shout = fetch[6:0];
                            if (kind != flash_pkg::kind_lock) begin
                                next_addr = addr + `ADDR_W'(1);  // R4 R5
                            end
                        end else begin
                            next_sout = shout[6];  // R2
                            next_shout = {shout[5:0], 1'b0};
                        end
                    end
                end
                flash_pkg::dev_ignore: begin
                    // Wait for deselect
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    // Command state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= flash_pkg::dev_idle;
            kind <= flash_pkg::kind_read;
            cnt <= 5'd0;
            shin <= 24'h000000;
            addr <= '0;
            shout <= 7'h00;
            obit <= 3'd0;
            sout <= 1'b0;
            oe <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            cnt <= next_cnt;
            shin <= next_shin;
            addr <= next_addr;
            shout <= next_shout;
            obit <= next_obit;
            sout <= next_sout;
            oe <= next_oe;
        end
    end

    assign link.serial_out = sout;
    assign link.serial_out_oe = oe;

    // Lock checks for memory writes and lock writes
    always_comb begin
        w_sec = mem_waddr[`SECTOR_HI:`SECTOR_LO];
        w_sub = mem_waddr[`SUB_HI:`SUB_LO];
        w_edge = (w_sec == `FIRST_SECTOR) || (w_sec == `LAST_SECTOR);
        w_blocked = sec_lock[w_sec][`LK_WLOCK];  // R15 R16
        if (legacy_mode && w_edge && sub_lock[w_sec[0]][w_sub][`LK_WLOCK]) begin
            w_blocked = 1'b1;  // R18
        end
        l_sec = lock_waddr[`SECTOR_HI:`SECTOR_LO];
        l_sub = lock_waddr[`SUB_HI:`SUB_LO];
        l_edge = (l_sec == `FIRST_SECTOR) || (l_sec == `LAST_SECTOR);
        next_sec_lock = sec_lock;
        next_sub_lock = sub_lock;
        if (lock_we) begin
            if (!sec_lock[l_sec][`LK_FREEZE]) begin
                next_sec_lock[l_sec] = lock_wdata[`LK_FREEZE:`LK_WLOCK];  // R14
            end
            // Frozen entries keep their value until reset
            if (legacy_mode && l_edge && !sub_lock[l_sec[0]][l_sub][`LK_FREEZE]) begin
                next_sub_lock[l_sec[0]][l_sub] =
                    lock_wdata[`LK_SUB_FREEZE:`LK_SUB_WLOCK];  // R18 R13
            end
        end
    end

    // Lock registers; reset clears every bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_lock <= '{default: 2'b00};  // R16 R13
            sub_lock <= '{default: '{default: 2'b00}};
            refused_q <= 1'b0;
        end else begin
            sec_lock <= next_sec_lock;
            sub_lock <= next_sub_lock;
            refused_q <= mem_we & w_blocked;
        end
    end

    // Array write port; locked sectors stay unchanged
    always_ff @(posedge pclk) begin
        if (mem_we && !w_blocked) begin
            mem[mem_waddr] <= mem_wdata;  // R15
        end
    end

    assign mem_refused = refused_q;
endmodule

// *** flash_read_host.sv ***
// Host controller issuing flash reads, steered over APB
// Assumes an APB master on pclk and the device end on the same pclk
`include "flash_cfg.svh"
module flash_read_host #(
    parameter logic [7:0] OP_READ = `OP_READ,
    parameter logic [7:0] OP_FAST = `OP_FAST,
    parameter logic [7:0] OP_LOCK = `OP_LOCK
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    flash_link_if.host_end link
);
    flash_pkg::host_state_e state, next_state;
    logic [1:0] cmd_sel, next_cmd_sel;   // Read kind selection
    logic [23:0] addr, next_addr;        // Start address
    logic [7:0] count, next_count;       // Bytes to read
    logic done, next_done;               // Transfer finished
    logic [7:0] rdata, next_rdata;       // Last byte received
    logic [3:0] div, next_div;           // Half period divider
    logic [39:0] tx, next_tx;            // Outgoing bits
    logic [5:0] tx_bits, next_tx_bits;   // Command, address and fast read dummy bits
    logic [11:0] bits, next_bits;        // Clocks issued
    logic [6:0] rx, next_rx;             // Incoming partial byte
    logic [2:0] rx_bit, next_rx_bit;     // Incoming bit index
    logic sel_n, next_sel_n;             // Select level
    logic sclk, next_sclk;               // Serial clock level
    logic wr;                            // APB write strobe
    logic tick;                          // Half period elapsed
    logic [11:0] total;                  // Clocks in the transfer
    logic [7:0] opcode;                  // Selected command byte

    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign tick = (div == `HALF_LAST);

    // Unmapped offsets answer with an error
    always_comb begin
        pslverr = 1'b0;
        prdata = 32'h00000000;
        unique case (paddr)
            `REG_CTRL: prdata = {30'h00000000, cmd_sel};
            `REG_ADDR: prdata = {8'h00, addr};
            `REG_COUNT: prdata = {24'h000000, count};
            `REG_STATUS: prdata = {30'h00000000, done, state != flash_pkg::host_idle};
            `REG_RDATA: prdata = {24'h000000, rdata};
            default: pslverr = psel & penable;
        endcase
    end

    // Next register and link state
    always_comb begin
        next_state = state;
        next_cmd_sel = cmd_sel;
        next_addr = addr;
        next_count = count;
        next_done = done;
        next_rdata = rdata;
        next_div = (state == flash_pkg::host_idle || tick) ? 4'd0 : div + 4'd1;
        next_tx = tx;
        next_tx_bits = tx_bits;
        next_bits = bits;
        next_rx = rx;
        next_rx_bit = rx_bit;
        next_sel_n = sel_n;
        next_sclk = sclk;
        total = 12'({count, 3'b000}) + 12'(tx_bits);
        unique case (pwdata[1:0])
            `SEL_FAST: opcode = OP_FAST;
            `SEL_LOCK: opcode = OP_LOCK;
            default: opcode = OP_READ;
        endcase
        unique case (state)
            flash_pkg::host_idle: begin
                // Settings only change between transfers
                if (wr && paddr == `REG_CTRL) begin
                    next_cmd_sel = pwdata[1:0];
                    if (pwdata[`CTRL_START]) begin
                        next_state = flash_pkg::host_lead;
                        next_done = 1'b0;
                        next_sel_n = 1'b0;
                        next_bits = 12'd0;
                        next_rx_bit = 3'd0;
                        next_tx = {opcode, addr, 8'h00};  // R1 R21 R9
                        next_tx_bits = (pwdata[1:0] == `SEL_FAST) ?
                            `TX_BITS_FAST : `TX_BITS_PLAIN;
                    end
                end
                if (wr && paddr == `REG_ADDR) begin
                    next_addr = pwdata[23:0];
                end
                if (wr && paddr == `REG_COUNT) begin
                    next_count = pwdata[7:0];
                end
            end
            flash_pkg::host_lead: begin
                // Select settles a full period before the first edge
                if (tick) begin
                    next_state = flash_pkg::host_run;
                end
            end
            flash_pkg::host_run: begin
                if (tick && !sclk) begin
                    next_sclk = 1'b1;
                    next_bits = bits + 12'd1;
                    if (bits >= 12'(tx_bits)) begin
                        // Sample device data on the rising edge
                        next_rx = {rx[5:0], link.serial_out_wire};
                        next_rx_bit = rx_bit + 3'd1;
                        if (rx_bit == 3'd7) begin
                            next_rdata = {rx, link.serial_out_wire};
                        end
                    end
                end else if (tick) begin
                    next_sclk = 1'b0;
                    next_tx = {tx[38:0], 1'b0};
                    if (bits == total) begin
                        next_state = flash_pkg::host_tail;
                    end
                end
            end
            flash_pkg::host_tail: begin
                // Deselect ends the read
                if (tick) begin
                    next_sel_n = 1'b1;  // R7
                    next_done = 1'b1;
                    next_state = flash_pkg::host_idle;
                end
            end
        endcase
    end

    // Register update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= flash_pkg::host_idle;
            cmd_sel <= `SEL_READ;
            addr <= 24'h000000;
            count <= 8'h01;
            done <= 1'b0;
            rdata <= 8'h00;
            div <= 4'd0;
            tx <= 40'h0000000000;
            tx_bits <= `TX_BITS_PLAIN;
            bits <= 12'd0;
            rx <= 7'h00;
            rx_bit <= 3'd0;
            sel_n <= 1'b1;
            sclk <= 1'b0;
        end else begin
            state <= next_state;
            cmd_sel <= next_cmd_sel;
            addr <= next_addr;
            count <= next_count;
            done <= next_done;
            rdata <= next_rdata;
            div <= next_div;
            tx <= next_tx;
            tx_bits <= next_tx_bits;
            bits <= next_bits;
            rx <= next_rx;
            rx_bit <= next_rx_bit;
            sel_n <= next_sel_n;
            sclk <= next_sclk;
        end
    end

    assign link.sel_n = sel_n;
    assign link.sclk = sclk;
    assign link.serial_in = tx[39];
endmodule

// *** link_sync.sv ***
// Two-flop synchroniser with edge detection on the synchronised level
// Assumes din is asynchronous to pclk
module link_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic q,
    output logic rise,
    output logic fall
);
    logic meta;  // First stage, read only by q
    logic last;  // Previous synchronised value

    // Stages registered; edges found between q and last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
            last <= RESET_VAL;
        end else begin
            meta <= din;
            q <= meta;
            last <= q;
        end
    end

    assign rise = q & ~last;
    assign fall = ~q & last;
endmodule

// *** serial_flash_read_and_lock_query_test.sv ***
// Bench: host and flash read port back to back, steered over APB
// Assumes the design files and flash_cfg.svh are compiled first
`include "flash_cfg.svh"
module serial_flash_read_and_lock_query_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy_flag, legacy_mode;
    logic mem_we, lock_we, mem_refused, seen_oe;
    logic [7:0] paddr, wd;
    logic [19:0] wa;
    logic [31:0] pwdata, prdata, r;
    int errors = 0, checks = 0, refused = 0;
    flash_link_if link();
    flash_read_device u_flash_read_device(.pclk, .presetn, .link, .busy_flag, .legacy_mode,
        .mem_we, .mem_waddr(wa), .mem_wdata(wd), .mem_refused, .lock_we, .lock_waddr(wa),
        .lock_wdata(wd));
    flash_read_host u_flash_read_host(.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .link);
    flash_link_sva u_flash_link_sva(.pclk, .presetn, .sel_n(link.sel_n), .sclk(link.sclk),
        .serial_in(link.serial_in), .serial_out(link.serial_out),
        .serial_out_oe(link.serial_out_oe));
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // Count refused array writes and note any drive of the pin
    always @(posedge pclk) begin
        if (mem_refused === 1'b1) refused++;
        if (link.serial_out_oe === 1'b1) seen_oe = 1;
    end
    task chk(input string n, input logic [31:0] s, x);
        checks++;
        if (s !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer, held until pready
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata | {pslverr, 31'h0};
        {psel, penable} <= 2'b00;
    endtask
    // Array or lock write on the user side
    task put(input logic lk, input logic [19:0] a, input logic [7:0] d);
        @(posedge pclk);
        {mem_we, lock_we, wa, wd} <= {!lk, lk, a, d};
        @(posedge pclk);
        {mem_we, lock_we} <= 2'b00;
    endtask
    // One read command, then fetch the last byte
    task op(input logic [1:0] k, input logic [23:0] a, input logic [7:0] n);
        bus(1, `REG_ADDR, {8'h0, a});
        bus(1, `REG_COUNT, {24'h0, n});
        bus(1, `REG_CTRL, {23'h0, 1'b1, 6'h0, k});
        do bus(0, `REG_STATUS, 32'h0);
        while (r[1] !== 1'b1);
        bus(0, `REG_RDATA, 32'h0);
        $display("read kind %0d at %h done", k, a);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #2ms;
        errors++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, busy_flag, legacy_mode} = '0;
        {mem_we, lock_we, wa, wd, seen_oe} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        put(0, 20'h00123, 8'h11);
        put(0, 20'h00124, 8'h22);
        put(0, 20'hfffff, 8'h33);
        put(0, 20'h00000, 8'h44);
        op(`SEL_READ, 24'h000123, 8'h02);
        chk("next byte", r, 32'h22);
        op(`SEL_READ, 24'h0fffff, 8'h02);
        chk("wrap", r, 32'h44);
        op(`SEL_READ, 24'ha00123, 8'h01);
        chk("high bits", r, 32'h11);
        op(`SEL_FAST, 24'h000124, 8'h01);
        chk("fast", r, 32'h22);
        op(`SEL_LOCK, 24'h04abcd, 8'h01);
        chk("lock reset", r, 32'h0);
        put(1, 20'h30000, 8'hf3);
        put(1, 20'h30000, 8'h00);
        put(1, 20'h20000, 8'h01);
        put(1, 20'h20000, 8'h00);
        put(0, 20'h20010, 8'h66);
        put(0, 20'h30010, 8'h77);
        op(`SEL_LOCK, 24'h03abcd, 8'h02);
        chk("frozen", r, 32'h03);
        op(`SEL_READ, 24'h020010, 8'h01);
        chk("open sector", r, 32'h66);
        chk("refused", refused, 32'h1);
        legacy_mode <= 1;
        put(1, 20'h02000, 8'h0c);
        put(1, 20'h52000, 8'h0c);
        op(`SEL_LOCK, 24'h002345, 8'h01);
        chk("subsector", r, 32'h0c);
        op(`SEL_LOCK, 24'h052000, 8'h01);
        chk("no subsector", r, 32'h0);
        busy_flag <= 1;
        seen_oe = 0;
        for (int k = 0; k < 3; k++)
            op(k[1:0], 24'h000123, 8'h01);
        chk("busy drive", seen_oe, 32'h0);
        busy_flag <= 0;
        op(`SEL_READ, 24'h000123, 8'h01);
        chk("after busy", r, 32'h11);
        end_of_test;
    end
endmodule
